// ==== hw/mql_pkg.sv ====
package mql_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Queue array geometry
    localparam int          QUEUE_MAX_N   = 32;
    localparam logic [4:0]  QUEUE_LAST    = 5'h1f;
    localparam logic [5:0]  QUEUE_ALL     = 6'h20;

    // Default split of memory per queue
    localparam logic [15:0] DEPTH_SMALL   = 16'h0400;
    localparam logic [15:0] DEPTH_LARGE   = 16'h0800;
    localparam logic [15:0] OFFSET_LOW    = 16'h0008;
    localparam logic [15:0] OFFSET_HIGH   = 16'h0080;

    ////////////////////////////////////////////////////////////////////////
    // Serial stream layout, most significant bit shifted first
    localparam logic [6:0]  HDR_BITS      = 7'h13;
    localparam logic [6:0]  REC_BITS      = 7'h48;
    localparam int          HDR_QCNT_MSB  = 4;
    localparam int          REC_DEPTH_MSB = 71;
    localparam int          REC_AE_MSB    = 55;
    localparam int          REC_AF_MSB    = 39;
    localparam int          REC_KEEP_LSB  = 24;
    localparam int          SETUP_W       = 48;

    // Cycles after reset before link toggles are trusted
    localparam logic [1:0]  SETTLE_LAST   = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Loader states
    typedef enum logic [4:0] {
        ST_SETTLE  = 5'h01,
        ST_DEFLOAD = 5'h02,
        ST_HDR     = 5'h04,
        ST_REC     = 5'h08,
        ST_DONE    = 5'h10
    } mql_state_t;

    typedef struct packed {
        mql_state_t  st;
        logic        dflt;
        logic        ofs_hi;
        logic [1:0]  settle;
        logic        tog_prev;
        logic [71:0] sh;
        logic [6:0]  cnt;
        logic [4:0]  qidx;
        logic [5:0]  qcount;
        logic [11:0] bits;
        logic [31:0] valid;
        logic        done;
        logic        stray;
        logic        rd_valid;
        logic [15:0] rd_depth;
        logic [15:0] rd_ae;
        logic [15:0] rd_af;
    } mql_core_t;

    typedef struct packed {
        logic tog;
        logic bit_v;
    } mql_link_t;

    localparam mql_core_t CORE_RESET = '{
        st: ST_SETTLE, dflt: 1'b0, ofs_hi: 1'b0, settle: 2'h0,
        tog_prev: 1'b0, sh: 72'h0, cnt: 7'h00, qidx: 5'h00,
        qcount: 6'h00, bits: 12'h000, valid: 32'h0, done: 1'b0,
        stray: 1'b0, rd_valid: 1'b0, rd_depth: 16'h0000,
        rd_ae: 16'h0000, rd_af: 16'h0000
    };

    localparam mql_link_t LINK_RESET = '{tog: 1'b0, bit_v: 1'b0};

endpackage

// ==== hw/mql_sync.sv ====
`timescale 1ns/1ps

module mql_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk,
    // Level from another domain
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // Stage 0 feeds only stage 1
    logic [1:0][W-1:0] stage_q;

    always_ff @(posedge clk) begin
        stage_q <= {stage_q[0], din};
    end

    assign dout = stage_q[1];

endmodule // mql_sync

// ==== hw/mql_setup_regs.sv ====
`timescale 1ns/1ps

module mql_setup_regs
    import mql_pkg::*;
(
    // Clock
    input  wire logic               clk,
    // Write port
    input  wire logic               wr_en,
    input  wire logic [4:0]         wr_addr,
    input  wire logic [SETUP_W-1:0] wr_data,
    // Read port
    input  wire logic [4:0]         rd_addr,
    output logic      [SETUP_W-1:0] rd_data
);

    // Depth, almost-empty and almost-full offset per queue
    logic [SETUP_W-1:0] mem [QUEUE_MAX_N];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule // mql_setup_regs

// ==== hw/mql_loader.sv ====
`timescale 1ns/1ps

// Behaviour
// - Serial mode stays unconfigured until loaded
// - One device takes 19 plus 72 per queue
// - Enabled serial clock edge captures data bit
// - All bits taken drives done output low
// - After done, enable output follows enable input
// - After done, data output follows data input
// - Chain needs n times single bit count
// - Thirty-two setup sets: depth, two offsets
// - Default mode ignores serial programming attempts
// - Default: 32 queues, 1024 or 2048 deep
// - Default offsets 8 or 128 by strap
// - Default load on core clocks after reset
// - Default chain: done feeds next enable
// - Master reset initialises and samples straps
module mql_loader
    import mql_pkg::*;
#(
    parameter logic LARGE_DENSITY = 1'b0
) (
    // Core clock and master reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    // Straps sampled during reset
    input  wire logic        DEFAULT_CONFIG_SELECT,
    input  wire logic        DEFAULT_OFFSET_SELECT,
    // Serial link
    input  wire logic        SERIAL_CLK,
    input  wire logic        SERIAL_DATA_IN,
    input  wire logic        SERIAL_LOAD_ENABLE_IN_N,
    output logic             SERIAL_DONE_ENABLE_OUT_N,
    output logic             SERIAL_DATA_OUT,
    // Load status
    output logic             CONFIGURED,
    output logic [5:0]       QUEUE_COUNT,
    output logic [11:0]      LOAD_BIT_COUNT,
    output logic             SERIAL_IGNORED,
    // Setup readback
    input  wire logic [4:0]  SETUP_RD_QUEUE,
    output logic             SETUP_RD_VALID,
    output logic [15:0]      SETUP_RD_DEPTH,
    output logic [15:0]      SETUP_RD_AE,
    output logic [15:0]      SETUP_RD_AF
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: one toggle per enabled serial edge, bit held beside it

    mql_link_t              l_q;
    mql_link_t              l_d;
    logic                   link_rst_n;

    mql_sync #(.W(1)) u_link_rst (
        .clk  (SERIAL_CLK),
        .din  (RESET_N),
        .dout (link_rst_n)
    );

    always_comb begin
        l_d = l_q;
        if (!link_rst_n) begin
            l_d = LINK_RESET;
        end else if (!SERIAL_LOAD_ENABLE_IN_N) begin
            l_d.tog   = ~l_q.tog;
            l_d.bit_v = SERIAL_DATA_IN;
        end
    end

    always_ff @(posedge SERIAL_CLK) begin
        l_q <= l_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the core domain

    logic                   tog_s;
    logic [1:0]             strap_s;

    // Bit is read only after its toggle is seen; it then stands a whole
    // serial period, so the serial clock must be slower than four core clocks
    mql_sync #(.W(1)) u_tog_sync (
        .clk  (CORE_CLK),
        .din  (l_q.tog),
        .dout (tog_s)
    );

    mql_sync #(.W(2)) u_strap_sync (
        .clk  (CORE_CLK),
        .din  ({DEFAULT_OFFSET_SELECT, DEFAULT_CONFIG_SELECT}),
        .dout (strap_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Core domain loader

    mql_core_t              q;
    mql_core_t              d;
    logic                   bit_ev;
    logic [71:0]            sh_nx;
    logic                   wr_en;
    logic [SETUP_W-1:0]     wr_data;
    logic [SETUP_W-1:0]     rd_data;
    logic [15:0]            def_depth;
    logic [15:0]            def_ofs;

    mql_setup_regs u_setup (
        .clk     (CORE_CLK),
        .wr_en   (wr_en),
        .wr_addr (q.qidx),
        .wr_data (wr_data),
        .rd_addr (SETUP_RD_QUEUE),
        .rd_data (rd_data)
    );

    assign def_depth = LARGE_DENSITY ? DEPTH_LARGE : DEPTH_SMALL;
    assign def_ofs   = q.ofs_hi ? OFFSET_HIGH : OFFSET_LOW;

    always_comb begin
        d       = q;
        wr_en   = 1'b0;
        wr_data = '0;
        bit_ev  = (tog_s != q.tog_prev);
        sh_nx   = {q.sh[70:0], l_q.bit_v};
        d.tog_prev = tog_s;

        unique case (q.st)
            // Toggle history after reset is stale until this passes
            ST_SETTLE: begin
                bit_ev = 1'b0;
                if (q.settle == SETTLE_LAST) begin
                    d.st = q.dflt ? ST_DEFLOAD : ST_HDR;
                end else begin
                    d.settle = q.settle + 2'h1;
                end
            end
            // One setup set per core clock, even split
            ST_DEFLOAD: begin
                wr_en   = 1'b1;
                wr_data = {def_depth, def_ofs, def_ofs};
                d.valid[q.qidx] = 1'b1;
                d.qidx = q.qidx + 5'h01;
                if (q.qidx == QUEUE_LAST) begin
                    d.qcount = QUEUE_ALL;
                    d.st     = ST_DONE;
                    d.done   = 1'b1;
                end
            end
            ST_HDR: begin
                if (bit_ev) begin
                    d.sh   = sh_nx;
                    d.bits = q.bits + 12'h001;
                    if (q.cnt == HDR_BITS - 7'h01) begin
                        d.cnt    = 7'h00;
                        d.qcount = {1'b0, sh_nx[HDR_QCNT_MSB:0]} + 6'h01;
                        d.st     = ST_REC;
                    end else begin
                        d.cnt = q.cnt + 7'h01;
                    end
                end
            end
            ST_REC: begin
                if (bit_ev) begin
                    d.sh   = sh_nx;
                    d.bits = q.bits + 12'h001;
                    d.cnt  = q.cnt + 7'h01;
                    if (q.cnt == REC_BITS - 7'h01) begin
                        wr_en   = 1'b1;
                        wr_data = sh_nx[REC_DEPTH_MSB:REC_KEEP_LSB];
                        d.valid[q.qidx] = 1'b1;
                        d.cnt  = 7'h00;
                        d.qidx = q.qidx + 5'h01;
                        if ({1'b0, q.qidx} + 6'h01 == q.qcount) begin
                            d.st   = ST_DONE;
                            d.done = 1'b1;
                        end
                    end
                end
            end
            // Later bits belong to devices further down the chain
            ST_DONE: begin
                d.done = 1'b1;
            end
        endcase

        // Serial edges in default mode are noted and otherwise dropped
        if (q.dflt && bit_ev) begin
            d.stray = 1'b1;
        end

        d.rd_valid = q.valid[SETUP_RD_QUEUE];
        d.rd_depth = rd_data[REC_DEPTH_MSB-REC_KEEP_LSB -: 16];
        d.rd_ae    = rd_data[REC_AE_MSB-REC_KEEP_LSB -: 16];
        d.rd_af    = rd_data[REC_AF_MSB-REC_KEEP_LSB -: 16];

        if (!RESET_N) begin
            d        = CORE_RESET;
            d.dflt   = strap_s[0];
            d.ofs_hi = strap_s[1];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the chain pass-through is combinational on purpose so a
    // downstream device sees the enable with no added delay

    assign SERIAL_DONE_ENABLE_OUT_N = q.done ? SERIAL_LOAD_ENABLE_IN_N
                                             : 1'b1;
    assign SERIAL_DATA_OUT = q.done & SERIAL_DATA_IN;
    assign CONFIGURED      = q.done;
    assign QUEUE_COUNT     = q.qcount;
    assign LOAD_BIT_COUNT  = q.bits;
    assign SERIAL_IGNORED  = q.stray;
    assign SETUP_RD_VALID  = q.rd_valid;
    assign SETUP_RD_DEPTH  = q.rd_depth;
    assign SETUP_RD_AE     = q.rd_ae;
    assign SETUP_RD_AF     = q.rd_af;

endmodule // mql_loader

// ==== tb/mql_loader_asserts.sv ====
`timescale 1ns/1ps
module mql_chk
    import mql_pkg::*;
(
    // Core side
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    input wire logic        DEFAULT_CONFIG_SELECT,
    input wire logic        CONFIGURED,
    input wire logic [5:0]  QUEUE_COUNT,
    input wire logic [11:0] LOAD_BIT_COUNT,
    // Serial link
    input wire logic        SERIAL_DATA_IN,
    input wire logic        SERIAL_LOAD_ENABLE_IN_N,
    input wire logic        SERIAL_DONE_ENABLE_OUT_N,
    input wire logic        SERIAL_DATA_OUT
);
    logic dflt_q;
    // Strap only counts as seen during reset
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            dflt_q <= DEFAULT_CONFIG_SELECT;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_settle;
        !CONFIGURED [*8];
    endsequence
    sequence s_full;
        CONFIGURED && QUEUE_COUNT == 6'h20;
    endsequence
    ////////////////////////////////////////////////////////////
    chk_reset_clear: assert property ($rose(RESET_N) |->
        !CONFIGURED && LOAD_BIT_COUNT == 12'h000) else $error("not cleared");
    chk_done_idle: assert property (!CONFIGURED |->
        SERIAL_DONE_ENABLE_OUT_N && !SERIAL_DATA_OUT) else $error("early");
    chk_enable_follow: assert property (CONFIGURED |->
        SERIAL_DONE_ENABLE_OUT_N == SERIAL_LOAD_ENABLE_IN_N) else $error("en");
    chk_data_follow: assert property (CONFIGURED |->
        SERIAL_DATA_OUT == SERIAL_DATA_IN) else $error("data pass");
    chk_conf_held: assert property (CONFIGURED |=> CONFIGURED)
        else $error("configured dropped");
    chk_default_time: assert property ($rose(RESET_N) && dflt_q |->
        s_settle ##[27:31] s_full) else $error("default load timing");
    chk_serial_refused: assert property (dflt_q |->
        LOAD_BIT_COUNT == 12'h000) else $error("bit taken in default");
    chk_bit_total: assert property (CONFIGURED && !dflt_q |->
        LOAD_BIT_COUNT == 12'h013 + 12'h048 * {6'h00, QUEUE_COUNT})
        else $error("bit total");
endmodule // mql_chk

bind mql_loader mql_chk u_mql_chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .DEFAULT_CONFIG_SELECT(DEFAULT_CONFIG_SELECT),
    .CONFIGURED(CONFIGURED), .QUEUE_COUNT(QUEUE_COUNT),
    .LOAD_BIT_COUNT(LOAD_BIT_COUNT), .SERIAL_DATA_IN(SERIAL_DATA_IN),
    .SERIAL_LOAD_ENABLE_IN_N(SERIAL_LOAD_ENABLE_IN_N),
    .SERIAL_DONE_ENABLE_OUT_N(SERIAL_DONE_ENABLE_OUT_N),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT)
);

// ==== tb/mql_ctrl_model.sv ====
`timescale 1ns/1ps
module mql_ctrl_model (
    // Frame request
    input  wire logic         start,
    input  wire logic [11:0]  nbits,
    input  wire logic [234:0] stream,
    input  wire logic [3:0]   gap,
    input  wire logic         pre_n,
    // Serial link
    output logic              sclk,
    output logic              sdi,
    output logic              sen_n,
    input  wire logic         done_n
);
    // Link state has no reset of its own until edges reach its reset sync,
    // so a short burst runs while the first reset is held; enable stays
    // low because the opening scenario is a default load
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        sen_n = 1'b0;
        repeat (4) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////
    // Apart from the opening burst, clock runs only inside a frame
    always @(posedge start) begin
        // Link reset sync needs edges before data
        sen_n = pre_n;
        repeat (4) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        sen_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = stream[nbits - 1 - i];
            #(32 + 10 * gap) sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        // Released line must not look held
        sdi = ~sdi;
        #64;
        if (!done_n) begin
            sen_n = 1'b1;
        end
    end
endmodule // mql_ctrl_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import mql_pkg::*;
;
    logic         clk, rst_n, dflt, ofs, start, pre_n, sclk, sdi;
    logic         sen_n, done_n, sdo, cfg, ign, rd_v;
    logic [3:0]   gap;
    logic [4:0]   rd_q;
    logic [5:0]   qcnt;
    logic [11:0]  nbits, bcnt;
    logic [15:0]  rd_d, rd_ae, rd_af;
    logic [234:0] stream;
    int           fails = 0;
    int           checks = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    mql_loader u_mql_loader (
        .CORE_CLK(clk), .RESET_N(rst_n), .DEFAULT_CONFIG_SELECT(dflt),
        .DEFAULT_OFFSET_SELECT(ofs), .SERIAL_CLK(sclk),
        .SERIAL_DATA_IN(sdi), .SERIAL_LOAD_ENABLE_IN_N(sen_n),
        .SERIAL_DONE_ENABLE_OUT_N(done_n), .SERIAL_DATA_OUT(sdo),
        .CONFIGURED(cfg), .QUEUE_COUNT(qcnt), .LOAD_BIT_COUNT(bcnt),
        .SERIAL_IGNORED(ign), .SETUP_RD_QUEUE(rd_q), .SETUP_RD_VALID(rd_v),
        .SETUP_RD_DEPTH(rd_d), .SETUP_RD_AE(rd_ae), .SETUP_RD_AF(rd_af)
    );
    mql_ctrl_model u_mql_ctrl_model (
        .start(start), .nbits(nbits), .stream(stream), .gap(gap),
        .pre_n(pre_n), .sclk(sclk), .sdi(sdi), .sen_n(sen_n),
        .done_n(done_n)
    );
    ////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset(input logic d, input logic o);
        @(posedge clk);
        rst_n <= 1'b0;
        dflt <= d;
        ofs <= o;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic send(input logic [11:0] n, input logic [3:0] g,
                        input logic p);
        @(posedge clk);
        nbits <= n;
        gap <= g;
        pre_n <= p;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic wait_cfg();
        for (int k = 0; k < 4000; k++) begin
            @(posedge clk);
            #1;
            if (cfg === 1'b1) begin
                return;
            end
        end
        fails++;
        give_verdict();
    endtask
    task automatic read_q(input logic [4:0] q, input logic v,
                          input logic [15:0] d, e, f);
        @(posedge clk);
        rd_q <= q;
        repeat (2) @(posedge clk);
        #1;
        cmp("valid", {15'h0000, v}, {15'h0000, rd_v});
        if (v) begin
            cmp("depth", d, rd_d);
            cmp("ae", e, rd_ae);
            cmp("af", f, rd_af);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        dflt = 1'b1;
        ofs = 1'b0;
        start = 1'b0;
        pre_n = 1'b0;
        nbits = 12'h000;
        gap = 4'h0;
        rd_q = 5'h00;
        stream = {72'h0, 14'h0000, 5'h01,
                  16'h0100, 16'h0010, 16'h0020, 24'ha5a5a5,
                  16'h0200, 16'h0003, 16'h0005, 24'h5a5a5a};
        // Default split, low offsets, stray serial bits
        do_reset(1'b1, 1'b0);
        wait_cfg();
        send(12'h003, 4'h0, 1'b0);
        cmp("queues", 16'h0020, {10'h000, qcnt});
        read_q(5'h1f, 1'b1, 16'h0400, 16'h0008, 16'h0008);
        repeat (60) @(posedge clk);
        cmp("ignored", 16'h0001, {15'h0000, ign});
        cmp("bits", 16'h0000, {4'h0, bcnt});
        // Second reset mid-run, high offsets
        do_reset(1'b1, 1'b1);
        send(12'h001, 4'h0, 1'b0);
        wait_cfg();
        read_q(5'h05, 1'b1, 16'h0400, 16'h0080, 16'h0080);
        // Serial load of two queues over a slow link
        do_reset(1'b0, 1'b0);
        read_q(5'h00, 1'b0, 16'h0000, 16'h0000, 16'h0000);
        send(12'h0a3, 4'h3, 1'b1);
        wait_cfg();
        cmp("done", 16'h0000, {15'h0000, done_n});
        cmp("queues", 16'h0002, {10'h000, qcnt});
        cmp("bits", 16'h00a3, {4'h0, bcnt});
        read_q(5'h00, 1'b1, 16'h0100, 16'h0010, 16'h0020);
        read_q(5'h01, 1'b1, 16'h0200, 16'h0003, 16'h0005);
        read_q(5'h02, 1'b0, 16'h0000, 16'h0000, 16'h0000);
        for (int k = 0; k < 100 && sen_n !== 1'b1; k++) begin
            @(posedge clk);
        end
        if (sen_n !== 1'b1) begin
            fails++;
            give_verdict();
        end
        #1;
        cmp("enable_out", 16'h0001, {15'h0000, done_n});
        cmp("data_out", {15'h0000, sdi}, {15'h0000, sdo});
        give_verdict();
    end
endmodule // tb_top
